/* File: rtl/mode_ctrl_pkg.sv */
// Package with register map, field positions and codes of the mode control registers.
package mode_ctrl_pkg;

    // ------------------------------------------------------------------
    // Register addresses and reset values.
    // ------------------------------------------------------------------
    localparam logic [5:0] ADDR_PROTOCOL  = 6'h00;
    localparam logic [5:0] ADDR_OPERATION = 6'h01;
    localparam logic [5:0] ADDR_LAST      = 6'h3F;
    localparam logic [7:0] PROTOCOL_RESET  = 8'h00;
    localparam logic [7:0] OPERATION_RESET = 8'h00;
    localparam logic [7:0] OPERATION_MASK  = 8'hF8;

    // ------------------------------------------------------------------
    // Field positions.
    // ------------------------------------------------------------------
    localparam int PEER_BIT      = 7;
    localparam int TYPE_B_BIT    = 6;
    localparam int TX_RATE_LSB   = 3;
    localparam int RX_RATE_LSB   = 0;
    localparam int READY_BIT     = 7;
    localparam int RX_EN_BIT     = 6;
    localparam int LOW_POWER_BIT = 5;
    localparam int TX_EN_BIT     = 4;
    localparam int LISTEN_BIT    = 3;

    // ------------------------------------------------------------------
    // Rate codes and serial frame.
    // ------------------------------------------------------------------
    localparam logic [2:0] RATE_106 = 3'h0;
    localparam logic [2:0] RATE_848 = 3'h3;
    localparam logic [1:0] MODE_WRITE = 2'h0;
    localparam logic [1:0] MODE_READ  = 2'h1;
    localparam logic [1:0] MODE_CMD   = 2'h3;
    localparam logic [5:0] CMD_SET_DEFAULT = 6'h01;
    localparam logic [5:0] CMD_PEER_TX     = 6'h0A;
    localparam logic [5:0] CMD_MASK_RX     = 6'h10;
    localparam logic [5:0] CMD_UNMASK_RX   = 6'h11;
    localparam logic [3:0] FRAME_BITS = 4'h8;

endpackage : mode_ctrl_pkg

/* File: rtl/mode_ctrl_regs.sv */
// Serial slave with protocol and operation control registers of the reader front end.
`timescale 1ns/1ps
`default_nettype none

module mode_ctrl_regs (
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic       spi_sclk,
    input  wire logic       spi_sen,
    input  wire logic       spi_mosi,
    input  wire logic       enable_pin,
    input  wire logic       field_detect,
    input  wire logic [7:0] display_value,
    output logic            spi_miso,
    output logic            spi_miso_oe,
    output logic            peer_mode,
    output logic            type_b,
    output logic [2:0]      tx_rate,
    output logic [2:0]      rx_rate,
    output logic            rate_reserved,
    output logic            ready_mode,
    output logic            receiver_enable,
    output logic            receiver_low_power,
    output logic            rf_output_enable,
    output logic            listen_irq,
    output logic            peer_tx_start,
    output logic            rx_masked,
    output logic            cmd_rejected
);

    // ------------------------------------------------------------------
    // Pin synchronisers and clock edge detection.
    // ------------------------------------------------------------------
    logic [1:0] sclk_s_q, sen_s_q, mosi_s_q, en_s_q, fld_s_q;
    logic       sclk_d1_q, fld_d1_q;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_s_q  <= 2'h0;
            sen_s_q   <= 2'h3;
            mosi_s_q  <= 2'h0;
            en_s_q    <= 2'h0;
            fld_s_q   <= 2'h0;
            sclk_d1_q <= 1'b0;
            fld_d1_q  <= 1'b0;
        end else begin
            sclk_s_q  <= {sclk_s_q[0], spi_sclk};
            sen_s_q   <= {sen_s_q[0], spi_sen};
            mosi_s_q  <= {mosi_s_q[0], spi_mosi};
            en_s_q    <= {en_s_q[0], enable_pin};
            fld_s_q   <= {fld_s_q[0], field_detect};
            sclk_d1_q <= sclk_s_q[1];
            fld_d1_q  <= fld_s_q[1];
        end
    end

    wire logic sel      = ~sen_s_q[1];
    wire logic sclk_ris = sclk_s_q[1] & ~sclk_d1_q;
    wire logic sclk_fal = ~sclk_s_q[1] & sclk_d1_q;

    // ------------------------------------------------------------------
    // Serial frame: mode(2) address(6), then one data byte.
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_HEAD = 3'b010,
        ST_DATA = 3'b100
    } frame_t;

    frame_t     state_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] shift_q;
    logic [1:0] mode_q;
    logic [5:0] addr_q;
    logic [7:0] tx_byte_q;
    logic [7:0] protocol_q;
    logic [7:0] operation_q;

    function automatic logic [7:0] read_mux(input logic [5:0] a, input logic [7:0] p,
                                            input logic [7:0] o, input logic [7:0] d);
        case (a)
            mode_ctrl_pkg::ADDR_PROTOCOL:  read_mux = p;
            mode_ctrl_pkg::ADDR_OPERATION: read_mux = o & mode_ctrl_pkg::OPERATION_MASK;
            default:                       read_mux = d;
        endcase
    endfunction : read_mux

    wire logic [7:0] shifted  = {shift_q[6:0], mosi_s_q[1]};
    wire logic       last_bit = sclk_ris && bit_cnt_q == mode_ctrl_pkg::FRAME_BITS - 4'h1;
    wire logic       head_done = state_q == ST_HEAD && last_bit;
    wire logic       wr_done   = state_q == ST_DATA && last_bit && mode_q == mode_ctrl_pkg::MODE_WRITE;
    wire logic       cmd_go    = head_done && shifted[7:6] == mode_ctrl_pkg::MODE_CMD;
    wire logic       restore   = cmd_go && shifted[5:0] == mode_ctrl_pkg::CMD_SET_DEFAULT;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q   <= ST_IDLE;
            bit_cnt_q <= 4'h0;
            shift_q   <= 8'h00;
            mode_q    <= 2'h0;
            addr_q    <= 6'h00;
        end else if (!sel) begin
            state_q   <= ST_IDLE;
            bit_cnt_q <= 4'h0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    state_q   <= ST_HEAD;
                    bit_cnt_q <= 4'h0;
                end
                ST_HEAD, ST_DATA: begin
                    if (sclk_ris) begin
                        shift_q   <= shifted;
                        bit_cnt_q <= last_bit ? 4'h0 : bit_cnt_q + 4'h1;
                        if (head_done) begin
                            mode_q  <= shifted[7:6];
                            addr_q  <= shifted[5:0];
                            state_q <= ST_DATA;
                        end
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Read data: loaded after the header, shifted out on falling edges.
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_byte_q   <= 8'h00;
            spi_miso    <= 1'b0;
            spi_miso_oe <= 1'b0;
        end else begin
            spi_miso_oe <= sel && state_q == ST_DATA && mode_q == mode_ctrl_pkg::MODE_READ;
            if (head_done) begin
                tx_byte_q <= read_mux(shifted[5:0], protocol_q, operation_q,
                                      display_value);
            end else if (sclk_fal && state_q == ST_DATA) begin
                spi_miso  <= tx_byte_q[7];
                tx_byte_q <= {tx_byte_q[6:0], 1'b0};
            end
        end
    end

    // ------------------------------------------------------------------
    // Configuration registers.
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            protocol_q  <= mode_ctrl_pkg::PROTOCOL_RESET;
            operation_q <= mode_ctrl_pkg::OPERATION_RESET;
        end else if (restore) begin
            protocol_q  <= mode_ctrl_pkg::PROTOCOL_RESET;
            operation_q <= mode_ctrl_pkg::OPERATION_RESET;
        end else if (wr_done) begin
            if (addr_q == mode_ctrl_pkg::ADDR_PROTOCOL) protocol_q <= shifted;
            if (addr_q == mode_ctrl_pkg::ADDR_OPERATION) begin
                operation_q <= shifted & mode_ctrl_pkg::OPERATION_MASK;
            end
        end
    end

    // ------------------------------------------------------------------
    // Control outputs, updated two cycles after the last data bit.
    // ------------------------------------------------------------------
    wire logic peer = protocol_q[mode_ctrl_pkg::PEER_BIT];
    wire logic rdy  = operation_q[mode_ctrl_pkg::READY_BIT] | en_s_q[1];
    wire logic rxon = operation_q[mode_ctrl_pkg::RX_EN_BIT];

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            peer_mode          <= 1'b0;
            type_b             <= 1'b0;
            tx_rate            <= mode_ctrl_pkg::RATE_106;
            rx_rate            <= mode_ctrl_pkg::RATE_106;
            rate_reserved      <= 1'b0;
            ready_mode         <= 1'b0;
            receiver_enable    <= 1'b0;
            receiver_low_power <= 1'b0;
            rf_output_enable   <= 1'b0;
        end else begin
            peer_mode <= peer;
            type_b    <= ~peer & protocol_q[mode_ctrl_pkg::TYPE_B_BIT];
            tx_rate   <= peer ? mode_ctrl_pkg::RATE_106
                              : protocol_q[mode_ctrl_pkg::TX_RATE_LSB +: 3];
            rx_rate   <= peer ? mode_ctrl_pkg::RATE_106
                              : protocol_q[mode_ctrl_pkg::RX_RATE_LSB +: 3];
            rate_reserved <= ~peer & (protocol_q[mode_ctrl_pkg::TX_RATE_LSB + 2]
                                      | protocol_q[mode_ctrl_pkg::RX_RATE_LSB + 2]);
            ready_mode         <= rdy;
            receiver_enable    <= rxon;
            receiver_low_power <= operation_q[mode_ctrl_pkg::LOW_POWER_BIT];
            rf_output_enable   <= operation_q[mode_ctrl_pkg::TX_EN_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Direct commands and listen interrupt.
    // ------------------------------------------------------------------
    wire logic is_peer_tx = cmd_go && shifted[5:0] == mode_ctrl_pkg::CMD_PEER_TX;
    wire logic is_mask    = cmd_go && shifted[5:0] == mode_ctrl_pkg::CMD_MASK_RX;
    wire logic is_unmask  = cmd_go && shifted[5:0] == mode_ctrl_pkg::CMD_UNMASK_RX;
    wire logic field_rise = fld_s_q[1] & ~fld_d1_q;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            peer_tx_start <= 1'b0;
            rx_masked     <= 1'b0;
            cmd_rejected  <= 1'b0;
            listen_irq    <= 1'b0;
        end else begin
            peer_tx_start <= is_peer_tx && peer && rdy;
            cmd_rejected  <= (is_peer_tx && !(peer && rdy))
                           || ((is_mask || is_unmask) && !rxon);
            if (is_mask && rxon) rx_masked <= 1'b1;
            else if (is_unmask && rxon) rx_masked <= 1'b0;
            listen_irq <= field_rise && operation_q[mode_ctrl_pkg::LISTEN_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------------
    a_peer_rates: assert property (@(posedge ref_clk) disable iff (!rst_n)
        peer_mode |-> tx_rate == mode_ctrl_pkg::RATE_106 && rx_rate == mode_ctrl_pkg::RATE_106)
        else $error("Peer mode rates not forced to 106.");
    a_type_b_gated: assert property (@(posedge ref_clk) disable iff (!rst_n)
        peer_mode |-> !type_b) else $error("Type B active in peer mode.");
    a_ready_or: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ##1 ready_mode == $past(rdy)) else $error("Ready not OR of bit and pin.");
    a_restore_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
        restore |=> protocol_q == 8'h00 && operation_q == 8'h00)
        else $error("Restore did not clear registers.");
    a_op_low_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
        operation_q[2:0] == 3'h0) else $error("Unused operation bits set.");
    a_write_lands: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_done && !restore && addr_q == mode_ctrl_pkg::ADDR_PROTOCOL
        |=> ##1 peer_mode == $past(shifted[7], 2)) else $error("Write too slow.");
    a_peer_tx_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
        peer_tx_start |-> $past(peer) && $past(rdy)) else $error("Peer transmit not gated.");
    a_mask_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $changed(rx_masked) |-> $past(rxon)) else $error("Mask changed with receiver off.");
    a_listen_irq: assert property (@(posedge ref_clk) disable iff (!rst_n)
        listen_irq |-> $past(operation_q[mode_ctrl_pkg::LISTEN_BIT]))
        else $error("Listen interrupt without listen mode.");
    a_rx_enable: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ##1 receiver_enable == $past(rxon)) else $error("Receiver enable mismatch.");

endmodule : mode_ctrl_regs

`default_nettype wire

/* File: tb/spi_host_model.sv */
// Serial host model that drives framed register accesses into the block.
`timescale 1ns/1ps
`default_nettype none

module spi_host_model (
    input  wire logic ref_clk,
    output logic      sclk,
    output logic      sen_n,
    output logic      mosi,
    input  wire logic miso,
    input  wire logic miso_oe
);
    initial begin
        sclk  = 1'b0;
        sen_n = 1'b1;
        mosi  = 1'b0;
    end

    // ------------------------------------------------------------------
    // Frame tasks.
    // ------------------------------------------------------------------
    task automatic half;
        repeat (4) @(negedge ref_clk);
    endtask : half

    task automatic frame(input logic [1:0] mode, input logic [5:0] addr,
                         input logic [7:0] data, input int nbits, output logic [7:0] rd);
        logic [15:0] sh;
        sh = {mode, addr, data};
        rd = 8'h00;
        @(negedge ref_clk);
        sen_n = 1'b0;
        half();
        for (int i = 0; i < nbits; i++) begin
            mosi = sh[15-i];
            half();
            sclk = 1'b1;
            half();
            if (i >= 8) begin
                rd = {rd[6:0], (miso_oe === 1'b1) ? miso : 1'bx};
            end
            sclk = 1'b0;
        end
        half();
        sen_n = 1'b1;
        mosi  = ~mosi;
        half();
    endtask : frame
endmodule : spi_host_model

`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for the mode control registers.
`timescale 1ns/1ps
`default_nettype none

module testbench;
    localparam logic [5:0] A_P = mode_ctrl_pkg::ADDR_PROTOCOL;
    localparam logic [5:0] A_O = mode_ctrl_pkg::ADDR_OPERATION;

    logic       ref_clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       enable_pin = 1'b0;
    logic       field_detect = 1'b0;
    logic [7:0] display_value = 8'hA5;
    wire logic  sclk, sen_n, mosi, miso, miso_oe;
    wire logic  peer_mode, type_b, rate_reserved, ready_mode, receiver_enable;
    wire logic  receiver_low_power, rf_output_enable, listen_irq, peer_tx_start;
    wire logic  rx_masked, cmd_rejected;
    wire logic [2:0] tx_rate, rx_rate;
    int         n_fail = 0;
    int         checks_done = 0;
    int         n_start = 0;
    int         n_rej = 0;
    int         n_irq = 0;

    always #10 ref_clk = ~ref_clk;

    mode_ctrl_regs dut (.ref_clk(ref_clk), .rst_n(rst_n), .spi_sclk(sclk), .spi_sen(sen_n),
        .spi_mosi(mosi), .enable_pin(enable_pin), .field_detect(field_detect),
        .display_value(display_value), .spi_miso(miso), .spi_miso_oe(miso_oe),
        .peer_mode(peer_mode), .type_b(type_b), .tx_rate(tx_rate), .rx_rate(rx_rate),
        .rate_reserved(rate_reserved), .ready_mode(ready_mode),
        .receiver_enable(receiver_enable), .receiver_low_power(receiver_low_power),
        .rf_output_enable(rf_output_enable), .listen_irq(listen_irq),
        .peer_tx_start(peer_tx_start), .rx_masked(rx_masked), .cmd_rejected(cmd_rejected));

    spi_host_model host (.ref_clk(ref_clk), .sclk(sclk), .sen_n(sen_n), .mosi(mosi),
        .miso(miso), .miso_oe(miso_oe));

    // ------------------------------------------------------------------
    // Pulse counters.
    // ------------------------------------------------------------------
    always @(negedge ref_clk) begin
        if (peer_tx_start === 1'b1) n_start++;
        if (cmd_rejected === 1'b1) n_rej++;
        if (listen_irq === 1'b1) n_irq++;
    end

    // ------------------------------------------------------------------
    // Access and compare tasks.
    // ------------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [7:0] r;
        host.frame(mode_ctrl_pkg::MODE_WRITE, a, d, 16, r);
    endtask : wr

    task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
        logic [7:0] r;
        host.frame(mode_ctrl_pkg::MODE_READ, a, 8'h00, 16, r);
        chk(r, exp, "read data");
    endtask : rd_chk

    task automatic cmd(input logic [5:0] c);
        logic [7:0] r;
        host.frame(mode_ctrl_pkg::MODE_CMD, c, 8'h00, 8, r);
    endtask : cmd

    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : summarize

    // ------------------------------------------------------------------
    // Main sequence.
    // ------------------------------------------------------------------
    initial begin
        repeat (4) @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge ref_clk);
        rd_chk(A_P, 8'h00);
        rd_chk(A_O, 8'h00);
        for (int r = 0; r < 4; r++) begin
            wr(A_P, {2'h0, 3'(r), 3'(3 - r)});
            chk({5'h00, tx_rate}, 8'(r), "tx rate");
            chk({5'h00, rx_rate}, 8'(3 - r), "rx rate");
            chk({7'h00, rate_reserved}, 8'h00, "reserved flag");
        end
        wr(A_P, 8'h40);
        chk({7'h00, type_b}, 8'h01, "type b");
        rd_chk(A_P, 8'h40);
        wr(A_P, 8'h24);
        chk({7'h00, rate_reserved}, 8'h01, "reserved flag");
        wr(A_P, 8'hDB);
        chk({6'h00, peer_mode, type_b}, 8'h02, "peer and type");
        chk({2'h0, tx_rate, rx_rate}, 8'h00, "peer rates");
        cmd(mode_ctrl_pkg::CMD_PEER_TX);
        chk(8'(n_start * 16 + n_rej), 8'h01, "peer tx without ready");
        enable_pin = 1'b1;
        repeat (4) @(negedge ref_clk);
        chk({7'h00, ready_mode}, 8'h01, "ready by pin");
        cmd(mode_ctrl_pkg::CMD_PEER_TX);
        chk(8'(n_start * 16 + n_rej), 8'h11, "peer tx accepted");
        enable_pin = 1'b0;
        wr(A_O, 8'hFF);
        rd_chk(A_O, 8'hF8);
        chk({4'h0, ready_mode, receiver_enable, receiver_low_power,
             rf_output_enable}, 8'h0F, "operation outputs");
        cmd(mode_ctrl_pkg::CMD_MASK_RX);
        chk({7'h00, rx_masked}, 8'h01, "masked");
        cmd(mode_ctrl_pkg::CMD_UNMASK_RX);
        chk({7'h00, rx_masked}, 8'h00, "unmasked");
        wr(A_O, 8'h28);
        rd_chk(A_O, 8'h28);
        chk({4'h0, ready_mode, receiver_enable, receiver_low_power,
             rf_output_enable}, 8'h02, "low power only");
        cmd(mode_ctrl_pkg::CMD_MASK_RX);
        chk(8'(n_rej), 8'h02, "mask refused");
        field_detect = 1'b1;
        for (int i = 0; i < 20 && n_irq == 0; i++) @(negedge ref_clk);
        chk(8'(n_irq), 8'h01, "listen interrupt");
        wr(6'h05, 8'h3C);
        rd_chk(6'h05, 8'hA5);
        rd_chk(mode_ctrl_pkg::ADDR_LAST, 8'hA5);
        rd_chk(A_P, 8'hDB);
        cmd(mode_ctrl_pkg::CMD_SET_DEFAULT);
        rd_chk(A_P, 8'h00);
        rd_chk(A_O, 8'h00);
        chk({7'h00, peer_mode}, 8'h00, "peer after restore");
        summarize();
    end
endmodule : testbench

`default_nettype wire
